// ---- core/ccce_pkg.sv ----
// Constants, decoded-instruction carrier and helper functions for the execution block
`default_nettype none
package ccce_pkg;

  // Register byte offsets on the AXI4-Lite slave
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_OPCODE = 8'h04;
  localparam logic [7:0] OFS_WORK = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_PCH_LATCH = 8'h10;
  localparam logic [7:0] OFS_PCU_LATCH = 8'h14;
  localparam logic [7:0] OFS_PC = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_INDEX_BASE = 8'h20;
  localparam logic [7:0] OFS_STACK = 8'h24;
  localparam logic [7:0] OFS_MEM_PTR = 8'h28;
  localparam logic [7:0] OFS_MEM_DATA = 8'h2c;

  // Field positions
  localparam int CTRL_EXT_BIT = 0;
  localparam int CTRL_BUSY_BIT = 8;
  localparam int STK_PTR_LSB = 24;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_OV_BIT = 3;
  localparam int ST_N_BIT = 4;
  localparam int ST_PWRDN_BIT = 5;
  localparam int ST_TIMEOUT_BIT = 6;

  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h60;
  localparam logic [20:0] PC_RST = 21'h000000;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  // Opcode encodings
  localparam logic [15:0] OPC_WDT_CLEAR = 16'h0004;
  localparam logic [15:0] OPC_CALL_WORK = 16'h0014;
  localparam logic [6:0] OPC_CLEAR_HI = 7'h35;
  localparam logic [5:0] OPC_INVERT_HI = 6'h07;

  // Addressing
  localparam logic [7:0] ILO_MAX = 8'h5f;
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam int MEM_AW = 12;
  localparam int MEM_DEPTH = 4096;

  // Sequencing
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [1:0] NOP_LAST = 2'h3;
  localparam logic [4:0] STK_MAX = 5'h1f;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic file_clear_op;
    logic file_invert_op;
    logic watchdog_clear_op;
    logic call_via_working_reg_op;
    logic dest_file;
    logic banked;
    logic [7:0] faddr;
  } ccce_dec_t;

  function automatic ccce_dec_t decode(input logic [15:0] op);
    ccce_dec_t d;
    d.file_clear_op = (op[15:9] == OPC_CLEAR_HI);
    d.file_invert_op = (op[15:10] == OPC_INVERT_HI);
    d.watchdog_clear_op = (op == OPC_WDT_CLEAR);
    d.call_via_working_reg_op = (op == OPC_CALL_WORK);
    d.dest_file = op[9];
    d.banked = op[8];
    d.faddr = op[7:0];
    return d;
  endfunction

  function automatic logic [MEM_AW-1:0] file_addr(input ccce_dec_t d, input logic [5:0] bank,
                                                  input logic [MEM_AW-1:0] base,
                                                  input logic ext_en);
    logic [MEM_AW-1:0] a;
    if (d.banked) begin
      a = {bank[3:0], d.faddr};
    end else if (ext_en && (d.faddr <= ILO_MAX)) begin
      a = base + {4'h0, d.faddr};
    end else if (d.faddr < ACC_SPLIT) begin
      a = {ACC_LO_BANK, d.faddr};
    end else begin
      a = {ACC_HI_BANK, d.faddr};
    end
    return a;
  endfunction

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage
`default_nettype wire

// ---- core/ccce_file_mem.sv ----
// Data memory of file registers with registered read data
`timescale 1ns/1ps
`default_nettype none
module ccce_file_mem (
  // Clock
  input wire logic aclk,
  // Port
  input wire logic we,
  input wire logic [ccce_pkg::MEM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);

  logic [7:0] mem [ccce_pkg::MEM_DEPTH];

  // Read before write on the same address
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_q <= mem[addr];
  end

endmodule
`default_nettype wire

// ---- core/ccce_exec.sv ----
// Execution unit for clear, watchdog-clear, complement and call-through-W instructions
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ccce_exec (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Core status
  output logic wdt_clear,
  output logic busy
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_DEC = 6'b000010,
    ST_RD = 6'b000100,
    ST_PROC = 6'b001000,
    ST_WR = 6'b010000,
    ST_NOP = 6'b100000
  } ccce_state_t;

  ccce_state_t state_q, state_d;
  logic [1:0] qcnt_q;
  logic [15:0] opcode_q;
  ccce_pkg::ccce_dec_t dec_q;
  logic [ccce_pkg::MEM_AW-1:0] addr_q;
  logic [7:0] res_q;
  logic [7:0] working_register_q;
  logic [5:0] bank_select_register_q;
  logic [7:0] pc_high_latch_q;
  logic [4:0] pc_upper_latch_q;
  logic [20:0] pc_q;
  logic [7:0] status_q;
  logic [ccce_pkg::MEM_AW-1:0] index_base_q;
  logic ext_en_q;
  logic [20:0] stack_top_q;
  logic [4:0] stk_ptr_q;
  logic [ccce_pkg::MEM_AW-1:0] mem_ptr_q;
  logic [7:0] mem_rdata;
  logic wdt_clear_q, busy_q;

  // Bus slave state
  logic awready_q, wready_q, aw_held_q, w_held_q, bvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [7:0] aw_addr_q, ar_addr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic arready_q, rd_pend_q, rd_go_q, rvalid_q;

  function automatic logic is_mapped(input logic [7:0] a);
    return (a == ccce_pkg::OFS_CTRL) || (a == ccce_pkg::OFS_OPCODE) ||
           (a == ccce_pkg::OFS_WORK) || (a == ccce_pkg::OFS_BANK) ||
           (a == ccce_pkg::OFS_PCH_LATCH) || (a == ccce_pkg::OFS_PCU_LATCH) ||
           (a == ccce_pkg::OFS_PC) || (a == ccce_pkg::OFS_STATUS) ||
           (a == ccce_pkg::OFS_INDEX_BASE) || (a == ccce_pkg::OFS_STACK) ||
           (a == ccce_pkg::OFS_MEM_PTR) || (a == ccce_pkg::OFS_MEM_DATA);
  endfunction

  // Software view of every register, zero above its width
  function automatic logic [31:0] reg_view(input logic [7:0] a);
    logic [31:0] v;
    v = ccce_pkg::WORD_ZERO;
    case (a)
      ccce_pkg::OFS_CTRL: begin
        v[ccce_pkg::CTRL_EXT_BIT] = ext_en_q;
        v[ccce_pkg::CTRL_BUSY_BIT] = busy_q;
      end
      ccce_pkg::OFS_OPCODE: v[15:0] = opcode_q;
      ccce_pkg::OFS_WORK: v[7:0] = working_register_q;
      ccce_pkg::OFS_BANK: v[5:0] = bank_select_register_q;
      ccce_pkg::OFS_PCH_LATCH: v[7:0] = pc_high_latch_q;
      ccce_pkg::OFS_PCU_LATCH: v[4:0] = pc_upper_latch_q;
      ccce_pkg::OFS_PC: v[20:0] = pc_q;
      ccce_pkg::OFS_STATUS: v[7:0] = status_q;
      ccce_pkg::OFS_INDEX_BASE: v[ccce_pkg::MEM_AW-1:0] = index_base_q;
      ccce_pkg::OFS_STACK: begin
        v[20:0] = stack_top_q;
        v[ccce_pkg::STK_PTR_LSB +: 5] = stk_ptr_q;
      end
      ccce_pkg::OFS_MEM_PTR: v[ccce_pkg::MEM_AW-1:0] = mem_ptr_q;
      ccce_pkg::OFS_MEM_DATA: v[7:0] = mem_rdata;
      default: v = ccce_pkg::WORD_ZERO;
    endcase
    return v;
  endfunction

  // Bus decode; register writes only land while the core is idle
  wire wr_do = aw_held_q && w_held_q && !busy_q && !bvalid_q;
  wire wr_ok = wr_do && is_mapped(aw_addr_q);
  wire [31:0] wr_val = ccce_pkg::apply_strb(reg_view(aw_addr_q), wdata_q, wstrb_q);
  wire start = wr_ok && (aw_addr_q == ccce_pkg::OFS_OPCODE);
  wire rd_issue = rd_pend_q && !busy_q;
  wire ccce_pkg::ccce_dec_t dec_w = ccce_pkg::decode(opcode_q);
  wire [20:0] pc_next = pc_q + ccce_pkg::PC_STEP;
  wire [20:0] call_target = {pc_upper_latch_q, pc_high_latch_q, working_register_q};

  // Memory port: core owns it while busy, software pointer otherwise
  wire core_mem_we = (state_q == ST_WR) &&
                     (dec_q.file_clear_op || (dec_q.file_invert_op && dec_q.dest_file));
  wire bus_mem_we = wr_ok && (aw_addr_q == ccce_pkg::OFS_MEM_DATA) && wstrb_q[0];
  wire mem_we = core_mem_we || bus_mem_we;
  wire [ccce_pkg::MEM_AW-1:0] mem_addr = busy_q ? addr_q : mem_ptr_q;
  wire [7:0] mem_wdata = busy_q ? res_q : wdata_q[7:0];

  ccce_file_mem u_mem (
    .aclk(aclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata_q(mem_rdata)
  );

  // Quarter-phase sequencer; the second cycle of a call is four idle quarters
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: state_d = start ? ST_DEC : ST_IDLE;
      ST_DEC: state_d = ST_RD;
      ST_RD: state_d = ST_PROC;
      ST_PROC: state_d = ST_WR;
      ST_WR: state_d = dec_q.call_via_working_reg_op ? ST_NOP : ST_IDLE;
      ST_NOP: state_d = (qcnt_q == ccce_pkg::NOP_LAST) ? ST_IDLE : ST_NOP;
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
      qcnt_q <= 2'h0;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      qcnt_q <= (state_q == ST_NOP) ? qcnt_q + 2'h1 : 2'h0;
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // Decode, address select and data processing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dec_q <= '0;
      addr_q <= '0;
      res_q <= 8'h00;
    end else if (state_q == ST_DEC) begin
      dec_q <= dec_w;
      addr_q <= ccce_pkg::file_addr(dec_w, bank_select_register_q, index_base_q,
                                    ext_en_q);
    end else if (state_q == ST_PROC) begin
      res_q <= dec_q.file_clear_op ? 8'h00 : ~mem_rdata;
    end
  end

  // Watchdog clear pulse in the write quarter, registered from the process quarter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_clear_q <= 1'b0;
    end else begin
      wdt_clear_q <= (state_q == ST_PROC) && dec_q.watchdog_clear_op;
    end
  end

  // Return stack top and depth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stack_top_q <= ccce_pkg::PC_RST;
      stk_ptr_q <= 5'h00;
    end else if ((state_q == ST_PROC) && dec_q.call_via_working_reg_op) begin
      stack_top_q <= pc_next;
      stk_ptr_q <= (stk_ptr_q == ccce_pkg::STK_MAX) ? stk_ptr_q : stk_ptr_q + 5'h01;
    end
  end

  // Programmer-visible registers: core writes while busy, software while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      opcode_q <= 16'h0000;
      working_register_q <= 8'h00;
      bank_select_register_q <= 6'h00;
      pc_high_latch_q <= 8'h00;
      pc_upper_latch_q <= 5'h00;
      pc_q <= ccce_pkg::PC_RST;
      status_q <= ccce_pkg::STATUS_RST;
      index_base_q <= '0;
      ext_en_q <= 1'b0;
      mem_ptr_q <= '0;
    end else if (busy_q) begin
      if ((state_q == ST_PROC) && dec_q.watchdog_clear_op) begin
        status_q[ccce_pkg::ST_TIMEOUT_BIT] <= 1'b1;
        status_q[ccce_pkg::ST_PWRDN_BIT] <= 1'b1;
      end
      if (state_q == ST_WR) begin
        pc_q <= dec_q.call_via_working_reg_op ? call_target : pc_next;
        if (dec_q.file_clear_op) begin
          status_q[ccce_pkg::ST_Z_BIT] <= 1'b1;
        end
        if (dec_q.file_invert_op) begin
          status_q[ccce_pkg::ST_N_BIT] <= res_q[7];
          status_q[ccce_pkg::ST_Z_BIT] <= (res_q == 8'h00);
          if (!dec_q.dest_file) begin
            working_register_q <= res_q;
          end
        end
      end
    end else if (wr_ok) begin
      case (aw_addr_q)
        ccce_pkg::OFS_CTRL: ext_en_q <= wr_val[ccce_pkg::CTRL_EXT_BIT];
        ccce_pkg::OFS_OPCODE: opcode_q <= wr_val[15:0];
        ccce_pkg::OFS_WORK: working_register_q <= wr_val[7:0];
        ccce_pkg::OFS_BANK: bank_select_register_q <= wr_val[5:0];
        ccce_pkg::OFS_PCH_LATCH: pc_high_latch_q <= wr_val[7:0];
        ccce_pkg::OFS_PCU_LATCH: pc_upper_latch_q <= wr_val[4:0];
        ccce_pkg::OFS_PC: pc_q <= wr_val[20:0];
        ccce_pkg::OFS_STATUS: status_q <= wr_val[7:0];
        ccce_pkg::OFS_INDEX_BASE: index_base_q <= wr_val[ccce_pkg::MEM_AW-1:0];
        ccce_pkg::OFS_MEM_PTR: mem_ptr_q <= wr_val[ccce_pkg::MEM_AW-1:0];
        default: mem_ptr_q <= mem_ptr_q;
      endcase
    end
  end

  // AXI4-Lite write channels, response after both halves held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q <= ccce_pkg::WORD_ZERO;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= ccce_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready_q) begin
        awready_q <= 1'b0;
        aw_held_q <= 1'b1;
        aw_addr_q <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready_q) begin
        wready_q <= 1'b0;
        w_held_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (wr_do) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? ccce_pkg::RESP_OKAY : ccce_pkg::RESP_SLVERR;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel; fixed two-step path covers the memory latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      ar_addr_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_go_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= ccce_pkg::WORD_ZERO;
      rresp_q <= ccce_pkg::RESP_OKAY;
    end else begin
      rd_go_q <= rd_issue;
      if (arvalid && arready_q) begin
        arready_q <= 1'b0;
        rd_pend_q <= 1'b1;
        ar_addr_q <= {araddr[7:2], 2'b00};
      end
      if (rd_issue) begin
        rd_pend_q <= 1'b0;
      end
      if (rd_go_q) begin
        rvalid_q <= 1'b1;
        rdata_q <= reg_view(ar_addr_q);
        rresp_q <= is_mapped(ar_addr_q) ? ccce_pkg::RESP_OKAY : ccce_pkg::RESP_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign wdt_clear = wdt_clear_q;
  assign busy = busy_q;

  // Checks
  sequence one_cycle_s;
    (state_q == ST_DEC) ##1 (state_q == ST_RD) ##1 (state_q == ST_PROC) ##1 (state_q == ST_WR);
  endsequence

  sequence nop_cycle_s;
    (state_q == ST_NOP) [*4] ##1 (state_q == ST_IDLE);
  endsequence

  clear_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_WR) && dec_q.file_clear_op |->
      mem_we && (mem_wdata == 8'h00) && (mem_addr == addr_q) ##1 status_q[ccce_pkg::ST_Z_BIT])
    else $error("clear did not write zero or set Z");

  clear_flags_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_WR) && dec_q.file_clear_op |=>
      $stable({status_q[ccce_pkg::ST_N_BIT], status_q[ccce_pkg::ST_OV_BIT],
               status_q[ccce_pkg::ST_DC_BIT], status_q[ccce_pkg::ST_C_BIT]}))
    else $error("clear disturbed N, OV, DC or C");

  bank_select_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_RD) && dec_q.banked |->
      (mem_addr == {bank_select_register_q[3:0], dec_q.faddr}))
    else $error("banked access used wrong address");

  indexed_addr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_RD) && !dec_q.banked && ext_en_q && (dec_q.faddr <= ccce_pkg::ILO_MAX) |->
      (mem_addr == index_base_q + {4'h0, dec_q.faddr}))
    else $error("indexed literal offset address wrong");

  wdt_clear_pulse_a: assert property (@(posedge aclk) disable iff (!aresetn)
    start && (wr_val[15:0] == ccce_pkg::OPC_WDT_CLEAR) |=> ##3 wdt_clear_q ##1 !wdt_clear_q)
    else $error("watchdog clear pulse missing or long");

  wdt_status_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_PROC) && dec_q.watchdog_clear_op |=>
      status_q[ccce_pkg::ST_TIMEOUT_BIT] && status_q[ccce_pkg::ST_PWRDN_BIT] &&
      ($past(status_q[4:0]) == status_q[4:0]))
    else $error("watchdog clear status update wrong");

  invert_result_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_WR) && dec_q.file_invert_op |->
      (res_q == ~$past(mem_rdata)) ##1 (status_q[ccce_pkg::ST_N_BIT] == $past(res_q[7])) &&
      (status_q[ccce_pkg::ST_Z_BIT] == ($past(res_q) == 8'h00)))
    else $error("complement result or flags wrong");

  invert_dest_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_WR) && dec_q.file_invert_op |->
      (mem_we == dec_q.dest_file) ##1 (dec_q.dest_file || (working_register_q == $past(res_q))))
    else $error("complement destination wrong");

  call_push_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_PROC) && dec_q.call_via_working_reg_op |=>
      (stack_top_q == $past(pc_q) + ccce_pkg::PC_STEP) ##1 (pc_q == $past(call_target)))
    else $error("call push or target load wrong");

  call_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DEC) && dec_w.call_via_working_reg_op |-> one_cycle_s ##1 nop_cycle_s)
    else $error("call did not take two cycles");

  single_length_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_q == ST_DEC) && !dec_w.call_via_working_reg_op |-> one_cycle_s ##1 (state_q == ST_IDLE))
    else $error("single-cycle instruction overran");

endmodule
`default_nettype wire

// ---- verif/ccce_exec_test.sv ----
// Register-level bench for the clear, watchdog-clear, complement and call execution unit
`timescale 1ns/1ps
`default_nettype none
module ccce_exec_test;
  logic aclk;
  logic aresetn;
  logic [7:0] awaddr;
  logic [7:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, wdt_clear, busy;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] rv;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [1:0] rs;
  int n_fail = 0;
  int check_count = 0;
  int wdt_cnt = 0;
  int busy_cnt = 0;

  ccce_exec ccce_exec_inst (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wdt_clear(wdt_clear), .busy(busy)
  );

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Pulse and busy-length counters, cleared by each instruction launch
  always @(posedge aclk) begin
    if (wdt_clear === 1'b1) wdt_cnt++;
    if (busy === 1'b1) busy_cnt++;
  end

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic hung;
    n_fail++;
    $display("CHECK FAILED at %0t: bus wait ran out, got %h exp %h", $time, 1'b0, 1'b1);
    test_done();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Write address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 200) hung();
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 200) hung();
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, ccce_pkg::RESP_OKAY});
  endtask

  task automatic mem_set(input logic [11:0] a, input logic [7:0] v);
    w(ccce_pkg::OFS_MEM_PTR, {20'h0, a});
    w(ccce_pkg::OFS_MEM_DATA, {24'h0, v});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
    w(ccce_pkg::OFS_MEM_PTR, {20'h0, a});
    rd_chk(ccce_pkg::OFS_MEM_DATA, {24'h0, v});
  endtask

  task automatic exec(input logic [15:0] op);
    busy_cnt = 0;
    wdt_cnt = 0;
    w(ccce_pkg::OFS_OPCODE, {16'h0, op});
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h00000000;
    wstrb = 4'hf;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(ccce_pkg::OFS_STATUS, {24'h0, ccce_pkg::STATUS_RST});
    rd_chk(ccce_pkg::OFS_PC, 32'h00000000);
    $display("test reset done");
    // Watchdog clear from a status with spare and arithmetic bits set
    w(ccce_pkg::OFS_STATUS, 32'h0000009b);
    exec(ccce_pkg::OPC_WDT_CLEAR);
    rd_chk(ccce_pkg::OFS_STATUS, 32'h000000fb);
    chk(wdt_cnt, 1);
    chk(busy_cnt, 4);
    $display("test watchdog done");
    // Banked clear must not touch the same offset in the access bank
    w(ccce_pkg::OFS_BANK, 32'h00000002);
    mem_set(12'h234, 8'h5a);
    mem_set(12'h034, 8'h77);
    exec(16'h6b34);
    mem_chk(12'h234, 8'h00);
    mem_chk(12'h034, 8'h77);
    rd_chk(ccce_pkg::OFS_STATUS, 32'h000000ff);
    chk(busy_cnt, 4);
    $display("test clear done");
    // Complement to W from low access bank, then to file in high access bank
    mem_set(12'h010, 8'h13);
    exec(16'h1c10);
    rd_chk(ccce_pkg::OFS_WORK, 32'h000000ec);
    mem_chk(12'h010, 8'h13);
    rd_chk(ccce_pkg::OFS_STATUS, 32'h000000fb);
    mem_set(12'hf80, 8'hff);
    exec(16'h1e80);
    mem_chk(12'hf80, 8'h00);
    rd_chk(ccce_pkg::OFS_WORK, 32'h000000ec);
    rd_chk(ccce_pkg::OFS_STATUS, 32'h000000ef);
    $display("test complement done");
    // Indexed offset at the last eligible address and just past it
    w(ccce_pkg::OFS_CTRL, 32'h00000001);
    w(ccce_pkg::OFS_INDEX_BASE, 32'h00000300);
    mem_set(12'h35f, 8'haa);
    mem_set(12'h05f, 8'haa);
    mem_set(12'hf60, 8'haa);
    mem_set(12'h360, 8'haa);
    exec(16'h6a5f);
    exec(16'h6a60);
    mem_chk(12'h35f, 8'h00);
    mem_chk(12'h05f, 8'haa);
    mem_chk(12'hf60, 8'h00);
    mem_chk(12'h360, 8'haa);
    $display("test indexed done");
    // Call through W after six single-cycle instructions
    w(ccce_pkg::OFS_WORK, 32'h00000006);
    w(ccce_pkg::OFS_PCH_LATCH, 32'h00000010);
    w(ccce_pkg::OFS_PCU_LATCH, 32'h00000001);
    exec(ccce_pkg::OPC_CALL_WORK);
    rd_chk(ccce_pkg::OFS_PC, 32'h00011006);
    rd_chk(ccce_pkg::OFS_STACK, 32'h0100000e);
    chk(busy_cnt, 8);
    rd_chk(ccce_pkg::OFS_STATUS, 32'h000000ef);
    $display("test call done");
    // A write whose strobes miss the latch's byte leaves the latch alone
    wstrb <= 4'h2;
    w(ccce_pkg::OFS_PCH_LATCH, 32'h0000ab00);
    wstrb <= 4'hf;
    rd_chk(ccce_pkg::OFS_PCH_LATCH, 32'h00000010);
    $display("test strobe done");
    // Unmapped offset answers with an error both ways
    wr(8'h40, 32'h00000001, rs);
    chk({30'h0, rs}, {30'h0, ccce_pkg::RESP_SLVERR});
    rd(8'h40, rv, rs);
    chk(rv, ccce_pkg::WORD_ZERO);
    chk({30'h0, rs}, {30'h0, ccce_pkg::RESP_SLVERR});
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
